// ---- src/pmcr_pkg.sv ----
// Shared constants and carriers for the master-side config register bank.
// Assumes a 12-bit APB byte address and a 256 MB processor master window.
package pmcr_pkg;

    // Register byte offsets
    localparam logic [11:0] PMCR_OFF_SUB_BASE = 12'h200;
    localparam logic [11:0] PMCR_OFF_MST_CTRL = 12'h300;
    localparam logic [11:0] PMCR_OFF_STATUS = 12'h304;
    localparam logic [11:0] PMCR_OFF_VENDEV = 12'h394;
    localparam logic [11:0] PMCR_OFF_CLREV = 12'h39C;
    localparam logic [11:0] PMCR_OFF_SUBID = 12'h3A0;
    localparam logic [11:0] PMCR_OFF_LATGNT = 12'h3A4;
    localparam logic [11:0] PMCR_OFF_CFGDONE = 12'h3AC;

    // Field positions in master_control
    localparam int PMCR_BIT_CFG_FLUSH = 10;
    localparam int PMCR_BIT_IO_FLUSH = 9;
    localparam int PMCR_BIT_MEM_FLUSH = 8;
    localparam int PMCR_BIT_RD_MULT = 2;
    localparam int PMCR_BIT_RD_LINE = 1;
    localparam int PMCR_BIT_WR_INV = 0;

    // Address substitution layout
    localparam int PMCR_SUB_LSB = 23;
    localparam int PMCR_SUB_W = 9;
    localparam int PMCR_SUB_CNT = 32;
    localparam int PMCR_IDX_W = 5;
    localparam int PMCR_WIN_W = 28;
    localparam int PMCR_LATGNT_W = 16;

    // Values after reset
    localparam logic [31:0] PMCR_CLREV_RST = 32'h1180_0001;
    localparam logic [31:0] PMCR_SUBID_RST = 32'h0000_0000;
    localparam logic [15:0] PMCR_LATGNT_RST = 16'h0000;
    localparam logic [8:0] PMCR_SUB_RST = 9'h000;
    localparam logic PMCR_CFGDONE_RST = 1'b0;

    // Bus command codes on the far side
    typedef enum logic [3:0] {
        PMCR_CMD_MEM_READ = 4'h6,
        PMCR_CMD_MEM_WRITE = 4'h7,
        PMCR_CMD_READ_MULT = 4'hC,
        PMCR_CMD_READ_LINE = 4'hE,
        PMCR_CMD_WRITE_INV = 4'hF
    } pmcr_cmd_t;

    typedef struct packed {
        logic cfg_flush_en;
        logic io_flush_en;
        logic mem_flush_en;
        logic read_multiple_allow;
        logic read_line_allow;
        logic write_invalidate_allow;
    } pmcr_ctrl_t;

    localparam pmcr_ctrl_t PMCR_CTRL_RST = '0;

    typedef struct packed {
        logic valid;
        logic [PMCR_WIN_W-1:0] addr;
    } pmcr_xreq_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } pmcr_xrsp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] beats;
    } pmcr_burst_t;

    typedef struct packed {
        logic valid;
        pmcr_cmd_t cmd;
    } pmcr_bcmd_t;

    typedef struct packed {
        logic [31:0] identity_mirror;
        logic [31:0] class_rev;
        logic [31:0] subsys;
        logic [PMCR_LATGNT_W-1:0] lat_grant;
    } pmcr_mirror_t;

endpackage

// ---- src/pmcr_regs.sv ----
// Master control, address substitution and configuration hook registers.
// Assumes an APB master on pclk, a PCI reset pin and a link clock pci_clk.
`timescale 1ns/10ps
module pmcr_regs
    import pmcr_pkg::*;
#(
    // Arbitrary neutral identity, not any real maker's code
    parameter logic [31:0] IDENTITY_DEFAULT = 32'h0001_0001,
    parameter int LINE_BEATS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pmcr_xreq_t xlat_req,
    output pmcr_xrsp_t xlat_rsp,
    input wire logic pci_rst_n,
    output pmcr_mirror_t mirror,
    input wire logic pci_clk,
    input wire logic bus_master_enable,
    input wire pmcr_burst_t burst_req,
    output pmcr_bcmd_t burst_cmd,
    output logic cfg_flush,
    output logic io_flush,
    output logic mem_flush,
    output logic ext_access_allow
);

    typedef struct packed {
        pmcr_ctrl_t ctrl;
        logic [PMCR_SUB_CNT-1:0][PMCR_SUB_W-1:0] sub;
        logic [31:0] vendev;
        logic [31:0] clrev;
        logic [31:0] subid;
        logic [PMCR_LATGNT_W-1:0] latgnt;
        logic cfg_done;
        logic rst_s1;
        logic rst_s2;
        pmcr_mirror_t mirror;
        logic [31:0] prdata;
        logic pslverr;
        pmcr_xrsp_t xrsp;
    } pmcr_pstate_t;

    typedef struct packed {
        pmcr_ctrl_t s1;
        logic s1_done;
        pmcr_ctrl_t s2;
        logic s2_done;
        pmcr_bcmd_t bcmd;
        logic cfg_flush;
        logic io_flush;
        logic mem_flush;
        logic allow;
    } pmcr_lstate_t;

    localparam int MULT_BEATS = 2 * LINE_BEATS;

    pmcr_pstate_t q;
    pmcr_pstate_t next_q;
    pmcr_lstate_t lq;
    pmcr_lstate_t next_lq;

    function automatic logic is_sub(input logic [11:0] a);
        is_sub = (a[11:7] == PMCR_OFF_SUB_BASE[11:7]);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = is_sub(a) || a == PMCR_OFF_MST_CTRL
            || a == PMCR_OFF_STATUS || a == PMCR_OFF_VENDEV
            || a == PMCR_OFF_CLREV || a == PMCR_OFF_SUBID
            || a == PMCR_OFF_LATGNT || a == PMCR_OFF_CFGDONE;
    endfunction

    logic setup_ph;
    logic wr_acc;
    logic [PMCR_IDX_W-1:0] wr_idx;
    logic [PMCR_IDX_W-1:0] x_idx;
    logic [31:0] x_addr;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign wr_idx = paddr[PMCR_IDX_W+1:2];
    // Window bits 27:23 select one of 32 eight-megabyte slices
    assign x_idx = xlat_req.addr[PMCR_WIN_W-1:PMCR_SUB_LSB];
    assign x_addr = {q.sub[x_idx], xlat_req.addr[PMCR_SUB_LSB-1:0]};

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign xlat_rsp = q.xrsp;
    assign mirror = q.mirror;

    always_comb begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        next_q = q;
        next_q.rst_s1 = pci_rst_n;
        next_q.rst_s2 = q.rst_s1;
        if (is_sub(paddr)) begin
            rd = {q.sub[wr_idx], 23'h00_0000};
        end else begin
            unique case (paddr)
                PMCR_OFF_MST_CTRL: begin
                    rd[PMCR_BIT_CFG_FLUSH] = q.ctrl.cfg_flush_en;
                    rd[PMCR_BIT_IO_FLUSH] = q.ctrl.io_flush_en;
                    rd[PMCR_BIT_MEM_FLUSH] = q.ctrl.mem_flush_en;
                    rd[PMCR_BIT_RD_MULT] = q.ctrl.read_multiple_allow;
                    rd[PMCR_BIT_RD_LINE] = q.ctrl.read_line_allow;
                    rd[PMCR_BIT_WR_INV] = q.ctrl.write_invalidate_allow;
                end
                PMCR_OFF_STATUS: rd[0] = !q.rst_s2;
                PMCR_OFF_VENDEV: rd = q.vendev;
                PMCR_OFF_CLREV: rd = q.clrev;
                PMCR_OFF_SUBID: rd = q.subid;
                PMCR_OFF_LATGNT: rd[PMCR_LATGNT_W-1:0] = q.latgnt;
                PMCR_OFF_CFGDONE: rd[0] = q.cfg_done;
                default: rd = 32'h0000_0000;
            endcase
        end
        if (setup_ph) begin
            next_q.prdata = pwrite ? 32'h0000_0000 : rd;
            next_q.pslverr = !is_mapped(paddr);
        end
        if (wr_acc) begin
            if (is_sub(paddr)) begin
                next_q.sub[wr_idx] = pwdata[31:PMCR_SUB_LSB];
            end else begin
                unique case (paddr)
                    PMCR_OFF_MST_CTRL: begin
                        next_q.ctrl.cfg_flush_en =
                            pwdata[PMCR_BIT_CFG_FLUSH];
                        next_q.ctrl.io_flush_en = pwdata[PMCR_BIT_IO_FLUSH];
                        next_q.ctrl.mem_flush_en =
                            pwdata[PMCR_BIT_MEM_FLUSH];
                        next_q.ctrl.read_multiple_allow =
                            pwdata[PMCR_BIT_RD_MULT];
                        next_q.ctrl.read_line_allow =
                            pwdata[PMCR_BIT_RD_LINE];
                        next_q.ctrl.write_invalidate_allow =
                            pwdata[PMCR_BIT_WR_INV];
                    end
                    PMCR_OFF_VENDEV: next_q.vendev = pwdata;
                    PMCR_OFF_CLREV: next_q.clrev = pwdata;
                    PMCR_OFF_SUBID: next_q.subid = pwdata;
                    PMCR_OFF_LATGNT: begin
                        next_q.latgnt = pwdata[PMCR_LATGNT_W-1:0];
                    end
                    PMCR_OFF_CFGDONE: next_q.cfg_done = pwdata[0];
                    default: next_q.cfg_done = q.cfg_done;
                endcase
            end
        end
        // Copy repeats while reset is held; last hook value wins
        if (!q.rst_s2) begin
            next_q.mirror.identity_mirror = q.vendev;
            next_q.mirror.class_rev = q.clrev;
            next_q.mirror.subsys = q.subid;
            next_q.mirror.lat_grant = q.latgnt;
        end
        next_q.xrsp.valid = xlat_req.valid;
        if (xlat_req.valid) begin
            next_q.xrsp.addr = x_addr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.ctrl <= PMCR_CTRL_RST;
            q.sub <= {PMCR_SUB_CNT{PMCR_SUB_RST}};
            q.vendev <= IDENTITY_DEFAULT;
            q.clrev <= PMCR_CLREV_RST;
            q.subid <= PMCR_SUBID_RST;
            q.latgnt <= PMCR_LATGNT_RST;
            q.cfg_done <= PMCR_CFGDONE_RST;
            q.rst_s1 <= 1'b0;
            q.rst_s2 <= 1'b0;
            q.mirror <= '0;
            q.prdata <= 32'h0000_0000;
            q.pslverr <= 1'b0;
            q.xrsp <= '0;
        end else begin
            q <= next_q;
        end
    end

    // Link side: control bits are quasi-static, so a level sync suffices
    always_comb begin
        next_lq = lq;
        next_lq.s1 = q.ctrl;
        next_lq.s1_done = q.cfg_done;
        next_lq.s2 = lq.s1;
        next_lq.s2_done = lq.s1_done;
        next_lq.cfg_flush = !bus_master_enable && lq.s2.cfg_flush_en;
        next_lq.io_flush = !bus_master_enable && lq.s2.io_flush_en;
        next_lq.mem_flush = !bus_master_enable && lq.s2.mem_flush_en;
        next_lq.allow = lq.s2_done;
        next_lq.bcmd.valid = burst_req.valid;
        if (burst_req.write) begin
            if (burst_req.beats >= 8'(LINE_BEATS)
                    && lq.s2.write_invalidate_allow) begin
                next_lq.bcmd.cmd = PMCR_CMD_WRITE_INV;
            end else begin
                next_lq.bcmd.cmd = PMCR_CMD_MEM_WRITE;
            end
        end else if (burst_req.beats >= 8'(MULT_BEATS)
                && lq.s2.read_multiple_allow) begin
            next_lq.bcmd.cmd = PMCR_CMD_READ_MULT;
        end else if (burst_req.beats >= 8'(LINE_BEATS)
                && lq.s2.read_line_allow) begin
            next_lq.bcmd.cmd = PMCR_CMD_READ_LINE;
        end else begin
            next_lq.bcmd.cmd = PMCR_CMD_MEM_READ;
        end
    end

    always_ff @(posedge pci_clk or negedge presetn) begin
        if (!presetn) begin
            lq.s1 <= PMCR_CTRL_RST;
            lq.s1_done <= 1'b0;
            lq.s2 <= PMCR_CTRL_RST;
            lq.s2_done <= 1'b0;
            lq.bcmd.valid <= 1'b0;
            lq.bcmd.cmd <= PMCR_CMD_MEM_READ;
            lq.cfg_flush <= 1'b0;
            lq.io_flush <= 1'b0;
            lq.mem_flush <= 1'b0;
            lq.allow <= 1'b0;
        end else begin
            lq <= next_lq;
        end
    end

    assign burst_cmd = lq.bcmd;
    assign cfg_flush = lq.cfg_flush;
    assign io_flush = lq.io_flush;
    assign mem_flush = lq.mem_flush;
    assign ext_access_allow = lq.allow;

    // Checks on the register clock
    property p_xlat;
        @(posedge pclk) disable iff (!presetn)
        xlat_req.valid |=> xlat_rsp.valid
            && xlat_rsp.addr == $past(x_addr);
    endproperty
    a_xlat: assert property (p_xlat)
        else $error("translated address wrong");

    property p_sub_map;
        @(posedge pclk) disable iff (!presetn)
        (xlat_req.valid && x_idx == 5'h1F) |=>
            xlat_rsp.addr[31:23] == $past(q.sub[31]);
    endproperty
    a_sub_map: assert property (p_sub_map)
        else $error("wrong substitution slot used");

    property p_sub_rsvd;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && is_sub(paddr)) |=> prdata[22:0] == 23'h0;
    endproperty
    a_sub_rsvd: assert property (p_sub_rsvd)
        else $error("substitution reserved bits not zero");

    property p_mirror;
        @(posedge pclk) disable iff (!presetn)
        !q.rst_s2 |=> mirror.identity_mirror == $past(q.vendev)
            && mirror.lat_grant == $past(q.latgnt);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("hook not copied on PCI reset");

    property p_vendev_wr;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == PMCR_OFF_VENDEV) |=> q.vendev == $past(pwdata);
    endproperty
    a_vendev_wr: assert property (p_vendev_wr)
        else $error("identity hook write lost");

    property p_done_rd;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && paddr == PMCR_OFF_CFGDONE)
            |=> prdata == {31'h0, $past(q.cfg_done)} && !pslverr;
    endproperty
    a_done_rd: assert property (p_done_rd)
        else $error("config done read wrong");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && !is_mapped(paddr)) |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    // Checks on the link clock
    property p_read_mult;
        @(posedge pci_clk) disable iff (!presetn)
        (burst_cmd.valid && burst_cmd.cmd == PMCR_CMD_READ_MULT)
            |-> $past(lq.s2.read_multiple_allow);
    endproperty
    a_read_mult: assert property (p_read_mult)
        else $error("read multiple issued while disallowed");

    property p_read_line;
        @(posedge pci_clk) disable iff (!presetn)
        (burst_cmd.valid && burst_cmd.cmd == PMCR_CMD_READ_LINE)
            |-> $past(lq.s2.read_line_allow);
    endproperty
    a_read_line: assert property (p_read_line)
        else $error("read line issued while disallowed");

    property p_write_inv;
        @(posedge pci_clk) disable iff (!presetn)
        (burst_req.valid && burst_req.write && !lq.s2.write_invalidate_allow)
            |=> burst_cmd.cmd == PMCR_CMD_MEM_WRITE;
    endproperty
    a_write_inv: assert property (p_write_inv)
        else $error("write invalidate issued while disallowed");

    property p_flush;
        @(posedge pci_clk) disable iff (!presetn)
        (!bus_master_enable && lq.s2.cfg_flush_en) [*2] |=> cfg_flush;
    endproperty
    a_flush: assert property (p_flush)
        else $error("config flush missing");

    property p_flush_io_mem;
        @(posedge pci_clk) disable iff (!presetn)
        bus_master_enable |=> !io_flush && !mem_flush;
    endproperty
    a_flush_io_mem: assert property (p_flush_io_mem)
        else $error("flush while master enabled");

    property p_allow;
        @(posedge pci_clk) disable iff (!presetn)
        !lq.s2_done |=> !ext_access_allow;
    endproperty
    a_allow: assert property (p_allow)
        else $error("external access allowed before done");

    c_xlat: cover property (@(posedge pclk) disable iff (!presetn)
        xlat_req.valid ##1 xlat_rsp.valid);
    c_mirror: cover property (@(posedge pclk) disable iff (!presetn)
        !q.rst_s2 ##1 q.rst_s2);
    c_mult: cover property (@(posedge pci_clk) disable iff (!presetn)
        burst_cmd.valid && burst_cmd.cmd == PMCR_CMD_READ_MULT);
    c_flush: cover property (@(posedge pci_clk) disable iff (!presetn)
        mem_flush);

endmodule

// ---- bench/pmcr_far_agent.sv ----
// Far-side bus agent: raises burst requests and drives the master enable.
// Assumes a free-running link clock, as a bus clock is.
`timescale 1ns/10ps
module pmcr_far_agent
    import pmcr_pkg::*;
(
    input wire logic pci_clk,
    output logic bus_master_enable,
    output pmcr_burst_t burst_req
);
    initial begin
        bus_master_enable = 1'b1;
        burst_req = '0;
    end

    task automatic set_master(input logic en);
        @(posedge pci_clk);
        bus_master_enable <= en;
    endtask

    task automatic burst(input logic wr, input logic [7:0] beats);
        @(posedge pci_clk);
        burst_req <= '{valid: 1'b1, write: wr, beats: beats};
        @(posedge pci_clk);
        // Released fields show garbage so stale values never pass
        burst_req <= '{valid: 1'b0, write: ~wr, beats: ~beats};
    endtask
endmodule

// ---- bench/pci_master_cfg_and_hook_regs_tb.sv ----
// Self-checking bench for the master config and hook register bank.
// Assumes zero-wait APB, registered answers and a 12 ns link clock.
`timescale 1ns/10ps
module pci_master_cfg_and_hook_regs_tb;
    import pmcr_pkg::*;
    // Arbitrary identity value, not any maker's code
    localparam logic [31:0] ID_DEF = 32'h5EED_0002;
    localparam int LB = 8;
    typedef struct packed {
        logic [31:0] data;
        logic err;
    } pmcr_rd_t;
    localparam logic [11:0] OFFS [7] = '{PMCR_OFF_VENDEV, PMCR_OFF_CLREV,
        PMCR_OFF_SUBID, PMCR_OFF_LATGNT, PMCR_OFF_CFGDONE, PMCR_OFF_MST_CTRL,
        PMCR_OFF_SUB_BASE};
    localparam logic [31:0] RSTV [7] = '{ID_DEF, PMCR_CLREV_RST,
        PMCR_SUBID_RST, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] MASK [7] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_0001, 32'h0000_0707,
        32'hFF80_0000};
    localparam logic [7:0] BEATS [5] = '{8'h07, 8'h08, 8'h0F, 8'h10, 8'hFF};
    localparam logic [31:0] FCTL [6] = '{32'h700, 32'h100, 32'h200,
        32'h400, 32'h000, 32'h700};

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, v, lo, ctl;
    pmcr_xreq_t xlat_req;
    pmcr_xrsp_t xlat_rsp;
    logic pci_rst_n, pci_clk, bus_master_enable;
    pmcr_mirror_t mirror;
    pmcr_burst_t burst_req;
    pmcr_bcmd_t burst_cmd;
    logic cfg_flush, io_flush, mem_flush, ext_access_allow;
    pmcr_rd_t rdq[$];
    pmcr_rd_t exp_rd;
    logic [31:0] xq[$];
    pmcr_cmd_t cq[$];
    logic [31:0] wv [7];
    logic [8:0] sub [32];
    int failures, samples_checked, n;

    pmcr_regs #(.IDENTITY_DEFAULT(ID_DEF), .LINE_BEATS(LB)) i_pmcr_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xlat_req(xlat_req),
        .xlat_rsp(xlat_rsp), .pci_rst_n(pci_rst_n), .mirror(mirror),
        .pci_clk(pci_clk), .bus_master_enable(bus_master_enable),
        .burst_req(burst_req), .burst_cmd(burst_cmd), .cfg_flush(cfg_flush),
        .io_flush(io_flush), .mem_flush(mem_flush),
        .ext_access_allow(ext_access_allow));

    pmcr_far_agent i_pmcr_far_agent (.pci_clk(pci_clk),
        .bus_master_enable(bus_master_enable), .burst_req(burst_req));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Odd start offset keeps the link clock out of phase
    initial begin
        pci_clk = 1'b0;
        #3.3;
        forever #6 pci_clk = ~pci_clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic pmcr_cmd_t exp_cmd(input logic wr,
                                          input logic [7:0] b,
                                          input logic [2:0] c);
        if (wr) begin
            return (b >= LB && c[0]) ? PMCR_CMD_WRITE_INV : PMCR_CMD_MEM_WRITE;
        end
        if (b >= 2 * LB && c[2]) begin
            return PMCR_CMD_READ_MULT;
        end
        if (b >= LB && c[1]) begin
            return PMCR_CMD_READ_LINE;
        end
        return PMCR_CMD_MEM_READ;
    endfunction

    task automatic wrap_up();
        if (rdq.size() + xq.size() + cq.size() != 0) begin
            failures++;
        end
        $display("checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input logic err);
        rdq.push_back('{data: exp, err: err});
        apb(1'b0, a, rnd());
    endtask

    task automatic link_wait();
        repeat (8) @(posedge pci_clk);
        #1;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            exp_rd = rdq.pop_front();
            check("prdata", prdata, exp_rd.data);
            check("pslverr", {31'h0, pslverr}, {31'h0, exp_rd.err});
        end
        if (xlat_rsp.valid === 1'b1) begin
            check("xlat addr", xlat_rsp.addr, xq.pop_front());
        end
    end

    always @(posedge pci_clk) begin
        if (burst_cmd.valid === 1'b1) begin
            check("cmd", 32'(burst_cmd.cmd), 32'(cq.pop_front()));
        end
    end

    initial begin
        #1_000_000;
        failures++;
        wrap_up();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        xlat_req = '0;
        pci_rst_n = 1'b1;
        failures = 0;
        samples_checked = 0;
        seed = 32'h0000_1AA2;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(OFFS[i], RSTV[i], 1'b0);
        end
        check("identity mirror", mirror.identity_mirror, ID_DEF);
        check("class mirror", mirror.class_rev, PMCR_CLREV_RST);
        check("ext allow", {31'h0, ext_access_allow}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            v = rnd();
            wv[i] = v & MASK[i];
            apb(1'b1, OFFS[i], v);
            rd(OFFS[i], wv[i], 1'b0);
        end
        // Holes in the map answer zero with an error, writes have no effect
        apb(1'b1, 12'h3A8, 32'hFFFF_FFFF);
        rd(12'h3A8, 32'h0, 1'b1);
        rd(12'h3F0, 32'h0, 1'b1);
        for (int i = 0; i < 32; i++) begin
            v = rnd();
            sub[i] = v[31:23];
            apb(1'b1, PMCR_OFF_SUB_BASE + 12'(i * 4), v);
        end
        for (int i = 0; i < 32; i++) begin
            rd(PMCR_OFF_SUB_BASE + 12'(i * 4), {sub[i], 23'h0}, 1'b0);
        end
        // Scrambled slot order, back to back
        for (int i = 0; i < 32; i++) begin
            lo = rnd();
            xq.push_back({sub[5'(i ^ 19)], lo[22:0]});
            @(posedge pclk);
            xlat_req <= '{valid: 1'b1, addr: {5'(i ^ 19), lo[22:0]}};
        end
        @(posedge pclk);
        xlat_req <= '{valid: 1'b0, addr: ~lo[27:0]};
        for (n = 0; n < 20 && xq.size() > 0; n++) @(posedge pclk);
        check("mirror held", mirror.identity_mirror, ID_DEF);
        @(posedge pclk);
        pci_rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(PMCR_OFF_STATUS, 32'h0000_0001, 1'b0);
        pci_rst_n <= 1'b1;
        repeat (6) @(posedge pclk);
        #1;
        check("identity mirror", mirror.identity_mirror, wv[0]);
        check("class mirror", mirror.class_rev, wv[1]);
        check("subsys mirror", mirror.subsys, wv[2]);
        check("latgnt mirror", {16'h0, mirror.lat_grant}, wv[3]);
        rd(PMCR_OFF_STATUS, 32'h0000_0000, 1'b0);
        apb(1'b1, PMCR_OFF_CFGDONE, 32'h1);
        link_wait();
        check("ext allow", {31'h0, ext_access_allow}, 32'h1);
        apb(1'b1, PMCR_OFF_CFGDONE, 32'h0);
        link_wait();
        check("ext allow", {31'h0, ext_access_allow}, 32'h0);
        for (int k = 0; k < 6; k++) begin
            ctl = FCTL[k];
            apb(1'b1, PMCR_OFF_MST_CTRL, ctl);
            i_pmcr_far_agent.set_master(k == 5);
            link_wait();
            v = (k == 5) ? 32'h0000_0000 : ctl;
            check("cfg flush", {31'h0, cfg_flush}, {31'h0, v[10]});
            check("io flush", {31'h0, io_flush}, {31'h0, v[9]});
            check("mem flush", {31'h0, mem_flush}, {31'h0, v[8]});
        end
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, PMCR_OFF_MST_CTRL, 32'(c));
            link_wait();
            for (int k = 0; k < 10; k++) begin
                cq.push_back(exp_cmd(k[0], BEATS[k / 2], 3'(c)));
                i_pmcr_far_agent.burst(k[0], BEATS[k / 2]);
            end
        end
        for (n = 0; n < 20 && cq.size() > 0; n++) @(posedge pci_clk);
        wrap_up();
    end
endmodule
